// File: hw/ist_init_detect.sv
`timescale 1ns/1ps
`default_nettype none
module ist_init_detect
	import ist_pkg::*;
(
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	// pattern view
	ist_init_if.det   pins
);

	// ************************************************************
	// pattern tracker
	// ************************************************************
	ist_state_e state;
	ist_state_e next_state;
	logic [2:0] idx;
	logic [2:0] next_idx;
	logic [1:0] pat;
	logic [2:0] idx_up;

	assign pat    = {pins.frame_pulse, pins.bit_clock};
	assign idx_up = 3'(idx + 3'h1);

	// next step of the seven step toggle pattern
	always_comb begin
		next_state = state;
		next_idx   = idx;
		unique case (state)
			IST_ST_HUNT: begin
				if (pins.quiet && !pins.superframe &&
					pat == IST_INIT_PAT[0]) begin // RULE3
					next_state = IST_ST_TRACK;
					next_idx   = IST_INIT_FIRST;
				end
			end
			IST_ST_TRACK: begin
				if (!pins.quiet || pins.superframe) begin // RULE3
					next_state = IST_ST_HUNT;
				end else if (pat == IST_INIT_PAT[idx]) begin
					next_idx = idx;
				end else if (pat == IST_INIT_PAT[idx_up]) begin
					next_idx = idx_up;
					if (idx_up == IST_INIT_LAST) begin // RULE2
						next_state = IST_ST_ARMED;
					end
				end else if (pat == IST_INIT_PAT[0]) begin
					next_idx = IST_INIT_FIRST;
				end else begin
					next_state = IST_ST_HUNT;
				end
			end
			IST_ST_ARMED: begin
				next_state = IST_ST_ARMED;
			end
			default: begin
				next_state = IST_ST_HUNT;
			end
		endcase
	end

	// state registers
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			state <= IST_ST_HUNT;
			idx   <= IST_INIT_FIRST;
		end else begin
			state <= next_state;
			idx   <= next_idx;
		end
	end

	assign pins.armed = (state == IST_ST_ARMED);

	// ************************************************************
	// checks
	// ************************************************************
	property p_arm_last;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state == IST_ST_TRACK && idx == 3'h5 && pins.quiet &&
		!pins.superframe && pat == 2'h1) |=> pins.armed;
	endproperty
	a_arm_last: assert property (p_arm_last) // RULE2
		else $error("init pattern end did not arm");

	property p_arm_noise;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state == IST_ST_TRACK && !pins.quiet) |=> state == IST_ST_HUNT;
	endproperty
	a_arm_noise: assert property (p_arm_noise) // RULE3
		else $error("init tracking survived a high input");

	c_armed: cover property (@(posedge i_sys_clk) $rose(pins.armed));

endmodule
`default_nettype wire

// File: hw/ist_init_if.sv
`timescale 1ns/1ps
`default_nettype none
// init pattern view shared between the top and the detector
interface ist_init_if;
	logic bit_clock;   // sampled bit clock pin
	logic frame_pulse; // sampled frame pulse pin
	logic superframe;  // sampled superframe pin
	logic quiet;       // every other init input but superframe held low
	logic armed;       // init pattern has been seen

	modport top (output bit_clock, frame_pulse, superframe, quiet,
		input armed);
	modport det (input bit_clock, frame_pulse, superframe, quiet,
		output armed);
endinterface
`default_nettype wire

// File: hw/ist_io_structure_test.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// RULE1: three test pins: enable, result, drive level
// RULE2: tester clears pins with init vectors first
// RULE3: init toggles clock/frame, other inputs low
// RULE4: mode set by two selects plus side
// RULE5: 1,0,1 chains inputs into result pin
// RULE6: chain covers streams, reset, oscillator, bidirs
// RULE7: result is odd parity of chained inputs
// RULE8: 1,1,0 drives outputs from drive pin
// RULE9: forced: data, control, open drain, result
// RULE10: 1,0,0 floats those same outputs
// RULE11: tester waits 800 ns before sampling
// RULE12: results follow pin levels, no edges
// RULE13: bidirs follow drive level, float in hiz
// RULE14: enable low keeps normal pin behaviour
module ist_io_structure_test
	import ist_pkg::*;
(
	// clock and reset
	input  wire logic i_sys_clk,
	input  wire logic i_resetn,
	// dedicated test pins and mode selects
	input  wire logic i_pin_test_enable,
	input  wire logic i_pin_test_drive_in,
	input  wire logic i_mode_select_0,
	input  wire logic i_mode_select_1,
	input  wire logic i_termination_side_select,
	output var  logic o_pin_test_result_out,
	output var  logic o_pin_test_result_out_oe,
	// digital input pins
	input  wire logic i_control_stream_in,
	input  wire logic i_data_stream_in,
	input  wire logic i_master_reset_in,
	input  wire logic i_oscillator_in,
	// two way pins
	input  wire logic i_bit_clock_io,
	output var  logic o_bit_clock_io,
	output var  logic o_bit_clock_io_oe,
	input  wire logic i_frame_pulse_io,
	output var  logic o_frame_pulse_io,
	output var  logic o_frame_pulse_io_oe,
	input  wire logic i_superframe_pulse_io,
	output var  logic o_superframe_pulse_io,
	output var  logic o_superframe_pulse_io_oe,
	// digital output pins
	output var  logic o_data_stream_out,
	output var  logic o_data_stream_out_oe,
	output var  logic o_control_stream_out,
	output var  logic o_control_stream_out_oe,
	output var  logic o_frame_pulse_open_drain_out,
	output var  logic o_frame_pulse_open_drain_out_oe,
	// functional core side
	input  wire logic i_core_data_stream_out,
	input  wire logic i_core_data_stream_out_oe,
	input  wire logic i_core_control_stream_out,
	input  wire logic i_core_control_stream_out_oe,
	input  wire logic i_core_frame_pulse_pull_low,
	input  wire logic i_core_bit_clock,
	input  wire logic i_core_bit_clock_oe,
	input  wire logic i_core_frame_pulse,
	input  wire logic i_core_frame_pulse_oe,
	input  wire logic i_core_superframe_pulse,
	input  wire logic i_core_superframe_pulse_oe
);

	// ************************************************************
	// mode decode and parity chain
	// ************************************************************
	localparam int SETTLE_MAX = IST_SETTLE_CYCLES;

	// test mode from enable, arming and the three selects
	function automatic ist_mode_e mode_of(input logic en,
		input logic armed, input logic [2:0] sel);
		ist_mode_e m;
		m = IST_FUNC;
		if (en && armed) begin // RULE14
			unique case (sel) // RULE4
				IST_SEL_INPUT:  m = IST_IN;
				IST_SEL_OUTPUT: m = IST_OUT;
				IST_SEL_HIZ:    m = IST_HIZ;
				default:        m = IST_FUNC;
			endcase
		end
		return m;
	endfunction

	ist_init_if init_bus ();
	ist_mode_e  mode;
	logic [2:0] sel;
	logic [6:0] chain;
	logic       parity;
	logic       drv;

	assign sel   = {i_mode_select_0, i_mode_select_1,
		i_termination_side_select};
	assign mode  = mode_of(i_pin_test_enable, init_bus.armed, sel);
	assign drv   = i_pin_test_drive_in;

	// every digital input joins the chain
	assign chain = {i_control_stream_in, i_data_stream_in,
		i_master_reset_in, i_oscillator_in, i_bit_clock_io,
		i_frame_pulse_io, i_superframe_pulse_io}; // RULE6
	assign parity = ^chain; // RULE7

	// view of the init pattern for the detector
	assign init_bus.bit_clock   = i_bit_clock_io;
	assign init_bus.frame_pulse = i_frame_pulse_io;
	assign init_bus.superframe  = i_superframe_pulse_io;
	assign init_bus.quiet       = !(i_pin_test_enable ||
		i_mode_select_0 || i_mode_select_1 ||
		i_termination_side_select || drv ||
		i_control_stream_in || i_data_stream_in ||
		i_master_reset_in || i_oscillator_in); // RULE3

	ist_init_detect u_init (
		.i_sys_clk (i_sys_clk),
		.i_resetn  (i_resetn),
		.pins      (init_bus.det)
	);

	// ************************************************************
	// pin drivers
	// ************************************************************
	ist_pins_s pins;
	ist_pins_s next_pins;

	// next pin levels; one clock keeps well inside the settle time
	always_comb begin
		next_pins            = IST_PINS_RST;
		next_pins.data_out   = i_core_data_stream_out;
		next_pins.data_oe    = i_core_data_stream_out_oe;
		next_pins.ctrl_out   = i_core_control_stream_out;
		next_pins.ctrl_oe    = i_core_control_stream_out_oe;
		next_pins.fp_od_oe   = i_core_frame_pulse_pull_low;
		next_pins.result_oe  = 1'b1;
		next_pins.clk_out    = i_core_bit_clock;
		next_pins.clk_oe     = i_core_bit_clock_oe;
		next_pins.fp_out     = i_core_frame_pulse;
		next_pins.fp_oe      = i_core_frame_pulse_oe;
		next_pins.sf_out     = i_core_superframe_pulse;
		next_pins.sf_oe      = i_core_superframe_pulse_oe;
		unique case (mode)
			IST_FUNC: begin
				next_pins.result_out = 1'b0; // RULE14
			end
			IST_IN: begin
				// tester owns the two way pins while it drives them
				next_pins.result_out = parity; // RULE5 RULE1
				next_pins.clk_oe     = 1'b0;
				next_pins.fp_oe      = 1'b0;
				next_pins.sf_oe      = 1'b0;
			end
			IST_OUT: begin
				next_pins.data_out   = drv; // RULE8 RULE9
				next_pins.data_oe    = 1'b1;
				next_pins.ctrl_out   = drv;
				next_pins.ctrl_oe    = 1'b1;
				next_pins.fp_od_oe   = !drv; // pull low for a 0
				next_pins.result_out = drv; // RULE1
				next_pins.clk_out    = drv; // RULE13
				next_pins.clk_oe     = 1'b1;
				next_pins.fp_out     = drv;
				next_pins.fp_oe      = 1'b1;
				next_pins.sf_out     = drv;
				next_pins.sf_oe      = 1'b1;
			end
			IST_HIZ: begin
				next_pins.data_oe    = 1'b0; // RULE10
				next_pins.ctrl_oe    = 1'b0;
				next_pins.fp_od_oe   = 1'b0;
				next_pins.result_oe  = 1'b0;
				next_pins.clk_oe     = 1'b0; // RULE13
				next_pins.fp_oe      = 1'b0;
				next_pins.sf_oe      = 1'b0;
			end
		endcase
	end

	// pin registers, no other state involved
	always_ff @(posedge i_sys_clk) begin
		if (!i_resetn) begin
			pins <= IST_PINS_RST;
		end else begin
			pins <= next_pins; // RULE12
		end
	end

	// outputs straight from the pin registers
	assign o_pin_test_result_out           = pins.result_out;
	assign o_pin_test_result_out_oe        = pins.result_oe;
	assign o_bit_clock_io                  = pins.clk_out;
	assign o_bit_clock_io_oe               = pins.clk_oe;
	assign o_frame_pulse_io                = pins.fp_out;
	assign o_frame_pulse_io_oe             = pins.fp_oe;
	assign o_superframe_pulse_io           = pins.sf_out;
	assign o_superframe_pulse_io_oe        = pins.sf_oe;
	assign o_data_stream_out               = pins.data_out;
	assign o_data_stream_out_oe            = pins.data_oe;
	assign o_control_stream_out            = pins.ctrl_out;
	assign o_control_stream_out_oe         = pins.ctrl_oe;
	assign o_frame_pulse_open_drain_out    = pins.fp_od_out;
	assign o_frame_pulse_open_drain_out_oe = pins.fp_od_oe;

	// ************************************************************
	// checks
	// ************************************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!i_resetn);

	property p_chain;
		mode == IST_IN |=> o_pin_test_result_out == $past(
		i_control_stream_in ^ i_data_stream_in ^ i_master_reset_in ^
		i_oscillator_in ^ i_bit_clock_io ^ i_frame_pulse_io ^
		i_superframe_pulse_io) && o_pin_test_result_out_oe;
	endproperty
	a_chain: assert property (p_chain) // RULE6
		else $error("result is not the chain of inputs");

	property p_odd;
		(mode == IST_IN && $countones(chain) % 2 == 1) |=>
		o_pin_test_result_out;
	endproperty
	a_odd: assert property (p_odd) // RULE7
		else $error("odd count did not give a one");

	property p_in_release;
		mode == IST_IN |=> !o_bit_clock_io_oe && !o_frame_pulse_io_oe &&
		!o_superframe_pulse_io_oe;
	endproperty
	a_in_release: assert property (p_in_release) // RULE5
		else $error("two way pin driven during input test");

	property p_force;
		mode == IST_OUT |=> o_data_stream_out == $past(drv) &&
		o_control_stream_out == $past(drv) &&
		o_pin_test_result_out == $past(drv) &&
		o_frame_pulse_open_drain_out_oe == !$past(drv) &&
		o_data_stream_out_oe && o_control_stream_out_oe;
	endproperty
	a_force: assert property (p_force) // RULE8
		else $error("outputs do not follow the drive pin");

	property p_force_bidir;
		mode == IST_OUT |=> o_bit_clock_io_oe && o_frame_pulse_io_oe &&
		o_superframe_pulse_io_oe &&
		o_superframe_pulse_io == $past(drv) &&
		o_frame_pulse_io == $past(drv) &&
		o_bit_clock_io == $past(drv);
	endproperty
	a_force_bidir: assert property (p_force_bidir) // RULE13
		else $error("two way pins do not follow the drive pin");

	property p_hiz;
		mode == IST_HIZ |=> !(o_data_stream_out_oe ||
		o_control_stream_out_oe || o_frame_pulse_open_drain_out_oe ||
		o_pin_test_result_out_oe || o_bit_clock_io_oe ||
		o_frame_pulse_io_oe || o_superframe_pulse_io_oe);
	endproperty
	a_hiz: assert property (p_hiz) // RULE10
		else $error("an output still drives in float mode");

	property p_off;
		!i_pin_test_enable |=> !o_pin_test_result_out &&
		o_data_stream_out == $past(i_core_data_stream_out) &&
		o_bit_clock_io_oe == $past(i_core_bit_clock_oe);
	endproperty
	a_off: assert property (p_off) // RULE14
		else $error("test path active with enable low");

	property p_bad_sel;
		(i_pin_test_enable && sel != IST_SEL_INPUT &&
		sel != IST_SEL_OUTPUT && sel != IST_SEL_HIZ) |=>
		!o_pin_test_result_out &&
		o_control_stream_out == $past(i_core_control_stream_out);
	endproperty
	a_bad_sel: assert property (p_bad_sel) // RULE4
		else $error("unlisted select code changed the pins");

	property p_settle;
		(mode == IST_OUT && $rose(drv)) ##1 (mode == IST_OUT && drv)
		|-> ##[0:SETTLE_MAX] o_data_stream_out;
	endproperty
	a_settle: assert property (p_settle) // RULE12
		else $error("forced output missed the settle time");

	c_in:  cover property (mode == IST_IN ##1 o_pin_test_result_out);
	c_out: cover property (mode == IST_OUT ##1 o_data_stream_out);
	c_hiz: cover property (mode == IST_HIZ ##1 !o_pin_test_result_out_oe);

endmodule
`default_nettype wire

// File: hw/ist_pkg.sv
`default_nettype none
package ist_pkg;

	// ************************************************************
	// timing of the static test
	// ************************************************************
	localparam int IST_TEST_DELAY_NS = 800; // longest pin to result delay
	localparam int IST_CLK_PERIOD_NS = 40;  // 25 MHz system clock
	localparam int IST_SETTLE_CYCLES =
		(IST_TEST_DELAY_NS / IST_CLK_PERIOD_NS < 1) ? 1 :
		IST_TEST_DELAY_NS / IST_CLK_PERIOD_NS;

	// ************************************************************
	// mode select codes {mode_select_0, mode_select_1, side}
	// ************************************************************
	localparam logic [2:0] IST_SEL_INPUT  = 3'h5; // 1,0,1
	localparam logic [2:0] IST_SEL_OUTPUT = 3'h6; // 1,1,0
	localparam logic [2:0] IST_SEL_HIZ    = 3'h4; // 1,0,0

	// ************************************************************
	// initialization pattern {frame_pulse, bit_clock} per step
	// ************************************************************
	localparam int         IST_INIT_STEPS = 7;
	localparam logic [2:0] IST_INIT_LAST  = 3'h6;
	localparam logic [2:0] IST_INIT_FIRST = 3'h0;
	localparam logic [1:0] IST_INIT_PAT [0:IST_INIT_STEPS-1] =
		'{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h2, 2'h1};

	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [1:0] {
		IST_FUNC = 2'h0,
		IST_IN   = 2'h1,
		IST_OUT  = 2'h2,
		IST_HIZ  = 2'h3
	} ist_mode_e;

	typedef enum logic [1:0] {
		IST_ST_HUNT  = 2'h0,
		IST_ST_TRACK = 2'h1,
		IST_ST_ARMED = 2'h2
	} ist_state_e;

	typedef struct packed {
		logic data_out;
		logic data_oe;
		logic ctrl_out;
		logic ctrl_oe;
		logic fp_od_out;
		logic fp_od_oe;
		logic result_out;
		logic result_oe;
		logic clk_out;
		logic clk_oe;
		logic fp_out;
		logic fp_oe;
		logic sf_out;
		logic sf_oe;
	} ist_pins_s;

	localparam ist_pins_s IST_PINS_RST = '0;

endpackage
`default_nettype wire

// File: tb/ist_io_structure_test_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
	n_compared++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); \
	end \
end

module ist_io_structure_test_bench
	import ist_pkg::*;
;
	logic        clk     = 1'b0;
	logic        rstn    = 1'b0;
	logic        ten     = 1'b0;
	logic        tin     = 1'b0;
	logic [2:0]  sel     = 3'h0; // {ms0, ms1, side}
	logic [3:0]  din     = 4'h0; // {osc, master_reset_in, data, ctrl}
	logic [10:0] core    = 11'h000;
	logic        init_go = 1'b0;
	logic [2:0]  tdrv    = 3'h0;
	logic        tdrv_en = 1'b0;
	logic        init_done;
	logic [2:0]  bi_val, bi_oe, lvl;
	logic        res, res_oe, dso, dso_oe, cso, cso_oe, odo, odo_oe;
	int          n_fail     = 0;
	int          n_compared = 0;

	// free running system clock
	always #(IST_CLK_PERIOD_NS / 2) clk = ~clk;

	ist_io_structure_test i_ist_io_structure_test (
		.i_sys_clk(clk), .i_resetn(rstn),
		.i_pin_test_enable(ten), .i_pin_test_drive_in(tin),
		.i_mode_select_0(sel[2]), .i_mode_select_1(sel[1]),
		.i_termination_side_select(sel[0]),
		.o_pin_test_result_out(res), .o_pin_test_result_out_oe(res_oe),
		.i_control_stream_in(din[0]), .i_data_stream_in(din[1]),
		.i_master_reset_in(din[2]), .i_oscillator_in(din[3]),
		.i_bit_clock_io(lvl[0]), .o_bit_clock_io(bi_val[0]),
		.o_bit_clock_io_oe(bi_oe[0]), .i_frame_pulse_io(lvl[1]),
		.o_frame_pulse_io(bi_val[1]), .o_frame_pulse_io_oe(bi_oe[1]),
		.i_superframe_pulse_io(lvl[2]), .o_superframe_pulse_io(bi_val[2]),
		.o_superframe_pulse_io_oe(bi_oe[2]),
		.o_data_stream_out(dso), .o_data_stream_out_oe(dso_oe),
		.o_control_stream_out(cso), .o_control_stream_out_oe(cso_oe),
		.o_frame_pulse_open_drain_out(odo),
		.o_frame_pulse_open_drain_out_oe(odo_oe),
		.i_core_data_stream_out(core[0]),
		.i_core_data_stream_out_oe(core[1]),
		.i_core_control_stream_out(core[2]),
		.i_core_control_stream_out_oe(core[3]),
		.i_core_frame_pulse_pull_low(core[4]),
		.i_core_bit_clock(core[5]), .i_core_bit_clock_oe(core[6]),
		.i_core_frame_pulse(core[7]), .i_core_frame_pulse_oe(core[8]),
		.i_core_superframe_pulse(core[9]),
		.i_core_superframe_pulse_oe(core[10])
	);

	ist_tester_model i_ist_tester_model (
		.i_sys_clk(clk), .i_init_go(init_go), .o_init_done(init_done),
		.i_drv(tdrv), .i_drv_en(tdrv_en), .i_dev_val(bi_val),
		.i_dev_oe(bi_oe), .o_wire(lvl)
	);

	// ************************************************************
	// scenarios
	// ************************************************************
	task stop_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// wait out the pin to result delay before sampling
	task settle;
		repeat (IST_SETTLE_CYCLES) @(negedge clk);
	endtask

	// every pin but the result follows the functional core; result driven low
	task check_func;
		`CHK({cso_oe, cso, dso_oe, dso}, core[3:0])
		`CHK({odo, odo_oe}, {1'b0, core[4]})
		`CHK(bi_val, {core[9], core[7], core[5]})
		`CHK(bi_oe, {core[10], core[8], core[6]})
		`CHK({res, res_oe}, 2'h1)
	endtask

	// a vector run broken by a high input, then an early enable:
	// the pins must stay functional
	task t_refused;
		int k;
		init_go = 1'b1;
		@(negedge clk);
		init_go = 1'b0;
		repeat (6) @(negedge clk);
		din = 4'h1; // breaks the quiet inputs mid-sequence
		@(negedge clk);
		din = 4'h0;
		for (k = 0; k < 40 && init_done !== 1'b1; k++)
			@(negedge clk);
		`CHK(init_done, 1'b1)
		ten = 1'b1;
		sel = 3'h5;
		core = 11'h5a5;
		settle();
		check_func();
		// selects back low so the next vector run sees quiet inputs
		ten = 1'b0;
		sel = 3'h0;
	endtask

	// run the init vectors with every other input low
	task t_init;
		int k;
		init_go = 1'b1;
		@(negedge clk);
		init_go = 1'b0;
		for (k = 0; k < 40 && init_done !== 1'b1; k++)
			@(negedge clk);
		`CHK(init_done, 1'b1)
		if (init_done !== 1'b1)
			stop_test();
		@(negedge clk);
	endtask

	// all 128 input patterns through the parity chain
	task t_input;
		logic [6:0] v;
		ten = 1'b1;
		sel = 3'h5;
		tdrv_en = 1'b1;
		for (int i = 0; i < 128; i++) begin
			v = 7'(i);
			din = v[3:0];
			tdrv = v[6:4];
			settle();
			`CHK(res, ^v)
			`CHK({res_oe, bi_oe}, 4'h8)
		end
		tdrv_en = 1'b0;
	endtask

	// outputs forced low then high from the drive pin
	task t_output;
		sel = 3'h6;
		for (int d = 0; d < 2; d++) begin
			tin = d[0];
			settle();
			`CHK({dso, cso, res, bi_val}, {6{d[0]}})
			`CHK({dso_oe, cso_oe, res_oe, bi_oe}, 6'h3f)
			`CHK({odo, odo_oe}, {1'b0, !d[0]})
		end
	endtask

	// straight from output test into float
	task t_hiz;
		sel = 3'h4;
		settle();
		`CHK({dso_oe, cso_oe, odo_oe, res_oe, bi_oe}, 7'h00)
	endtask

	// unused select codes leave the pins functional
	task t_codes;
		for (int c = 0; c < 8; c++) begin
			if (c == 4 || c == 5 || c == 6)
				continue;
			sel = 3'(c);
			core = ~core;
			settle();
			check_func();
		end
	endtask

	// enable low with a test code present
	task t_enable_low;
		ten = 1'b0;
		sel = 3'h6;
		core = 11'h2aa;
		settle();
		check_func();
	endtask

	// a fresh reset drops the init state
	task t_rearm;
		rstn = 1'b0;
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		ten = 1'b1;
		sel = 3'h5;
		settle();
		check_func();
	endtask

	// main sequence
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		@(negedge clk);
		t_refused();
		t_init();
		t_input();
		t_output();
		t_hiz();
		t_codes();
		t_enable_low();
		t_rearm();
		stop_test();
	end
endmodule
`default_nettype wire

// File: tb/ist_tester_model.sv
`timescale 1ns/1ps
`default_nettype none
module ist_tester_model
	import ist_pkg::*;
(
	// clock
	input  wire logic       i_sys_clk,
	// init sequence control
	input  wire logic       i_init_go,
	output var  logic       o_init_done,
	// bench drive of the two way pins {sf, fp, clk}
	input  wire logic [2:0] i_drv,
	input  wire logic       i_drv_en,
	// device drive of the two way pins
	input  wire logic [2:0] i_dev_val,
	input  wire logic [2:0] i_dev_oe,
	// resolved pin levels
	output var  logic [2:0] o_wire
);
	logic [3:0] step      = 4'h0;
	logic       busy      = 1'b0;
	logic [2:0] float_pat = 3'h5;
	logic [2:0] t_val;
	logic       t_en;

	// walk the init vectors, two cycles per vector
	always @(posedge i_sys_clk) begin
		float_pat <= ~float_pat;
		if (i_init_go && !busy) begin
			busy <= 1'b1;
			step <= 4'h0;
			o_init_done <= 1'b0;
		end else if (busy) begin
			if (step == 4'hd) begin
				busy <= 1'b0;
				o_init_done <= 1'b1;
			end
			step <= step + 4'h1;
		end
	end

	// superframe stays low while the vectors run
	always_comb begin
		t_en = busy | i_drv_en;
		t_val = busy ? {1'b0, IST_INIT_PAT[step[3:1]]} : i_drv;
	end

	// tester wins, then device, else an undriven net wanders
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			o_wire[k] = t_en ? t_val[k] :
				(i_dev_oe[k] ? i_dev_val[k] : float_pat[k]);
		end
	end
endmodule
`default_nettype wire
